//--- adcsd_adc_model.sv
// Behavioural serial converter on the controller's far side
`timescale 1ns/1ns
module adcsd_adc_model (
  input  wire logic   sclk,    // Shift clock
  input  wire logic   cs_n,    // Select, low
  input  wire logic   din,     // Command bit
  output logic        dout,    // Result bit
  output logic [11:0] last_cmd // Last command taken
);
  logic [11:0] sh_q = 12'h000;
  logic [11:0] res_q = 12'h000;
  logic [11:0] out_q;
  initial dout = 1'b0;
  // Previous result goes out MSB first as the frame opens
  always @(negedge cs_n) begin
    out_q = res_q;
    dout <= res_q[11];
  end
  // capture on rise; the clock reaches us slightly delayed
  // so the bit launched with the rise is the one taken
  always @(posedge sclk) begin
    if (!cs_n) begin
      out_q <= out_q << 1;
      dout <= out_q[10];
      #2 sh_q <= {sh_q[10:0], din};
    end
  end
  always @(posedge cs_n) begin
    last_cmd = sh_q;
    dout <= ~dout;
    case (sh_q[11:8])
      4'hB: res_q = 12'h800;
      4'hC: res_q = 12'h000;
      4'hD: res_q = 12'hFFF;
      4'hE: res_q = 12'h000;
      default: res_q = {3{sh_q[11:8]}};
    endcase
  end
endmodule : adcsd_adc_model

//--- adcsd_cfg.svh
// Timing counts, command fields and display constants for the channel controller
`ifndef ADCSD_CFG_SVH
`define ADCSD_CFG_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define ADCSD_CLK_MHZ        125
`define ADCSD_SLOW_PERIOD_US 500000
`define ADCSD_FAST_PERIOD_NS 33000
`define ADCSD_CONV_TIME_NS   10000
`define ADCSD_SCLK_HALF_NS   200
`define ADCSD_FLASH_HALF_US  250000
`define ADCSD_SLOW_CYC  (`ADCSD_SLOW_PERIOD_US * `ADCSD_CLK_MHZ)
`define ADCSD_FAST_CYC  ((`ADCSD_FAST_PERIOD_NS * `ADCSD_CLK_MHZ) / 1000)
`define ADCSD_CONV_CYC  ((`ADCSD_CONV_TIME_NS * `ADCSD_CLK_MHZ + 999) / 1000)
`define ADCSD_SCLK_CYC  ((`ADCSD_SCLK_HALF_NS * `ADCSD_CLK_MHZ + 999) / 1000)
`define ADCSD_FLASH_CYC (`ADCSD_FLASH_HALF_US * `ADCSD_CLK_MHZ)
`define ADCSD_FLASH_TOGGLES 4'h6

// ****************************************************************
// Serial command and switch codes, flash digits and FIFO depth
// ****************************************************************
`define ADCSD_CMD_BITS   12
`define ADCSD_CMD_LOW    8'h00
`define ADCSD_CODE_PDOWN 4'hE
`define ADCSD_CODE_FAST  4'hF
`define ADCSD_FAST_CHAN  4'h4
`define ADCSD_FLASH_DIGITS 12'h888
`define ADCSD_FIFO_DEPTH 16

`endif

//--- adcsd_checker.sv
// Port assertions for the channel controller
`timescale 1ns/1ns
module adcsd_checker #(
  parameter int SLOW_CYC = 3000,
  parameter int FAST_CYC = 2500
) (
  input wire logic        clk,                   // Clock
  input wire logic        rst_n,                 // Reset, low
  input wire logic [3:0]  channel_select_switch, // Code
  input wire logic        ctrl_serial_data_out,  // Bit out
  input wire logic        ctrl_serial_clock_out, // Serial clock
  input wire logic        conv_cs_n,             // Select, low
  input wire logic [11:0] display_digits         // Digits
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        cs_q;
  logic [15:0] gap_q;
  logic [31:0] per_q;
  logic [1:0]  mode_q;
  logic        fast;
  assign fast = (channel_select_switch == 4'hF);
  // Frame spacing; counters saturate so a long stall never wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q   <= 1'b1;
      gap_q  <= 16'hFFFF;
      per_q  <= 32'h0000_0000;
      mode_q <= 2'h0;
    end else begin
      cs_q <= conv_cs_n;
      if (!cs_q && conv_cs_n) gap_q <= 16'h0001;
      else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
      // Wide enough for the real slow period
      if (cs_q && !conv_cs_n) per_q <= 32'h0000_0001;
      else if (per_q != 32'hFFFF_FFFF) per_q <= per_q + 32'h0000_0001;
      if (cs_q && !conv_cs_n) mode_q <= fast ? 2'h2 : 2'h1;
    end
  end
  a_idle_clk_low: assert property (
    conv_cs_n |-> !ctrl_serial_clock_out) else $error("clock out of frame");
  a_idle_data_low: assert property (
    conv_cs_n |-> !ctrl_serial_data_out) else $error("data out of frame");
  a_data_at_rise: assert property (
    !conv_cs_n && !$past(conv_cs_n) && !$rose(ctrl_serial_clock_out)
    |-> $stable(ctrl_serial_data_out)) else $error("data moved off rise");
  a_clock_half: assert property (
    $rose(ctrl_serial_clock_out) |-> ctrl_serial_clock_out[*8])
    else $error("clock high too short");
  a_frame_len: assert property (
    $fell(conv_cs_n) |-> ##[600:600] $rose(conv_cs_n))
    else $error("frame length wrong");
  a_conv_wait: assert property (
    $fell(conv_cs_n) |-> gap_q >= 16'd1250) else $error("no conversion wait");
  a_slow_rate: assert property (
    $fell(conv_cs_n) && !fast && mode_q == 2'h1
    |-> per_q >= SLOW_CYC - 1 && per_q <= SLOW_CYC + 1)
    else $error("slow period wrong");
  a_fast_rate: assert property (
    $fell(conv_cs_n) && fast && mode_q == 2'h2 |-> per_q >= FAST_CYC - 1)
    else $error("fast period short");
  a_flash_start: assert property (
    $rose(rst_n) |=> display_digits == 12'h888) else $error("no flash");
endmodule : adcsd_checker

bind adcsd_ctrl adcsd_checker #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC))
  u_chk (.clk(clk), .rst_n(rst_n),
  .channel_select_switch(channel_select_switch),
  .ctrl_serial_data_out(ctrl_serial_data_out),
  .ctrl_serial_clock_out(ctrl_serial_clock_out),
  .conv_cs_n(conv_cs_n), .display_digits(display_digits));

//--- adcsd_ctrl.sv
// Channel-select controller with serial converter port and hex displays
`timescale 1ns/1ns
`include "adcsd_cfg.svh"

// ****************************************************************
// Sample FIFO
// ****************************************************************
module adcsd_fifo #(
  parameter int W     = 13,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rst_n,     // Async reset, active low
  input  wire logic [W-1:0] in_data,   // Fill data
  input  wire logic         in_valid,  // Fill request
  output logic              in_ready,  // Space available
  output logic [W-1:0]      out_data,  // Head word
  output logic              out_valid, // Head word present
  input  wire logic         out_ready  // Drain accepts
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         push;
  logic         pop;

  // Extra pointer bit tells full from empty
  assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end
endmodule : adcsd_fifo

// ****************************************************************
// Controller top
// ****************************************************************
// Contract
// - After reset, flash all digits, then show converted readings.
// - Switch is one 4-bit code, left position most significant.
// - Codes 0h to Ah select converter analog channels 0 to 10.
// - Codes Bh, Ch, Dh select the internal reference tests.
// - Code Eh commands converter power-down and blanks the displays.
// - Code Fh selects user input four, conversions back to back, fast; the code starts one every FAST_CYC cycles (33 us).
// - All other codes convert and update at about two per second.
// - Sampled switch code goes out serially as the next channel command.
// - Shift back the 12-bit result, show it as three hex digits.
// - Outgoing data changes to the next bit at each rising clock edge.
// - Held in reset while supervisor asserts it, runs on release.
module adcsd_ctrl #(
  parameter int SLOW_CYC  = `ADCSD_SLOW_CYC,
  parameter int FAST_CYC  = `ADCSD_FAST_CYC,
  parameter int FLASH_CYC = `ADCSD_FLASH_CYC
) (
  input  wire logic        clk,                   // 125 MHz clock
  input  wire logic        rst_n,                 // Supervisor reset, low
  input  wire logic [3:0]  channel_select_switch, // [3] is leftmost
  input  wire logic        ctrl_serial_data_in,   // Converter data out
  output logic             ctrl_serial_data_out,  // Command bit
  output logic             ctrl_serial_clock_out, // Serial clock
  output logic             conv_cs_n,             // Converter select, low
  input  wire logic        disp_ready,            // Displays accept update
  output logic [11:0]      display_digits,        // Three hex digits
  output logic             display_blank          // Blank all digits
);
  localparam int CONV_CYC = `ADCSD_CONV_CYC;
  localparam int SCLK_CYC = `ADCSD_SCLK_CYC;

  adcsd_pkg::adcsd_state_type  state_q;
  adcsd_pkg::adcsd_sample_type fill_data;
  adcsd_pkg::adcsd_sample_type head_data;
  logic [31:0] period_q;
  logic [15:0] sub_q;
  logic [3:0]  flash_cnt_q;
  logic        flash_blank_q;
  logic [3:0]  code_q;
  logic [11:0] tx_q;
  logic [11:0] rx_q;
  logic [3:0]  bit_q;
  logic        sclk_q;
  logic        dout_q;
  logic        cs_n_q;
  logic        fill_ready;
  logic        head_valid;
  logic        pop;
  logic [31:0] period_lim;
  logic [11:0] digits_q;
  logic        blank_q;

  // Fast mode decode, shared by pacing and command build
  function automatic logic is_fast(input logic [3:0] code);
    is_fast = (code == `ADCSD_CODE_FAST);
  endfunction : is_fast

  function automatic logic [3:0] chan_addr(input logic [3:0] code);
    chan_addr = is_fast(code) ? `ADCSD_FAST_CHAN : code;
  endfunction : chan_addr

  // pacing choice follows the live switch
  assign period_lim = is_fast(channel_select_switch) ?
                      32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1);

  // Period counter restarts at each exchange start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_q <= '0;
    end else if (state_q == adcsd_pkg::ST_WAIT && period_q >= period_lim) begin
      period_q <= '0;
    end else if (state_q == adcsd_pkg::ST_INIT && flash_cnt_q != 4'h0 &&
                 period_q >= 32'(FLASH_CYC - 1)) begin
      // Each flash phase gets a full flash period, not a single cycle
      period_q <= '0;
    end else if (period_q != 32'hFFFF_FFFF) begin
      period_q <= period_q + 32'h0000_0001;
    end
  end

  // reset entry; flash, then pace exchanges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= adcsd_pkg::ST_INIT;
      sub_q         <= '0;
      flash_cnt_q   <= `ADCSD_FLASH_TOGGLES;
      flash_blank_q <= 1'b0;
      code_q        <= '0;
      tx_q          <= '0;
      rx_q          <= '0;
      bit_q         <= '0;
      sclk_q        <= 1'b0;
      dout_q        <= 1'b0;
      cs_n_q        <= 1'b1;
    end else begin
      case (state_q)
        adcsd_pkg::ST_INIT: begin
          // Flash timer is wide, so it borrows the period counter
          if (period_q >= 32'(FLASH_CYC - 1) && flash_cnt_q != 4'h0) begin
            flash_blank_q <= ~flash_blank_q;
            flash_cnt_q   <= flash_cnt_q - 4'h1;
          end
          if (flash_cnt_q == 4'h0) begin
            flash_blank_q <= 1'b0;
            state_q       <= adcsd_pkg::ST_WAIT;
          end
        end
        adcsd_pkg::ST_WAIT: begin
          if (period_q >= period_lim) begin
            // latch code and build the command word
            code_q <= channel_select_switch;
            tx_q   <= {chan_addr(channel_select_switch), `ADCSD_CMD_LOW};
            cs_n_q  <= 1'b0;
            bit_q   <= '0;
            sub_q   <= '0;
            state_q <= adcsd_pkg::ST_XFER;
          end
        end
        adcsd_pkg::ST_XFER: begin
          if (sub_q >= 16'(SCLK_CYC - 1)) begin
            sub_q <= '0;
            if (!sclk_q) begin
              // next bit goes out with the rising edge; the
              // converter's delayed clock edge takes that same bit
              sclk_q <= 1'b1;
              tx_q   <= {tx_q[10:0], 1'b0};
              dout_q <= tx_q[11];
              rx_q   <= {rx_q[10:0], ctrl_serial_data_in};
              bit_q  <= bit_q + 4'h1;
            end else begin
              sclk_q <= 1'b0;
              if (bit_q == 4'(`ADCSD_CMD_BITS)) begin
                // close the frame, start conversion wait
                cs_n_q  <= 1'b1;
                dout_q  <= 1'b0;
                state_q <= adcsd_pkg::ST_CONV;
              end
            end
          end else begin
            sub_q <= sub_q + 16'h0001;
          end
        end
        adcsd_pkg::ST_CONV: begin
          // no new command until the conversion time passes
          if (sub_q >= 16'(CONV_CYC - 1)) begin
            sub_q   <= '0;
            state_q <= adcsd_pkg::ST_PUSH;
          end else begin
            sub_q <= sub_q + 16'h0001;
          end
        end
        adcsd_pkg::ST_PUSH: begin
          // A full FIFO stalls the sequence here
          if (fill_ready) begin
            state_q <= adcsd_pkg::ST_WAIT;
          end
        end
        default: begin
          state_q <= adcsd_pkg::ST_INIT;
        end
      endcase
    end
  end

  // power-down readings travel as blank entries
  assign fill_data.blank = (code_q == `ADCSD_CODE_PDOWN);
  assign fill_data.value = rx_q;
  assign pop = head_valid && disp_ready && (state_q != adcsd_pkg::ST_INIT);

  adcsd_fifo #(
    .W     ($bits(adcsd_pkg::adcsd_sample_type)),
    .DEPTH (`ADCSD_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (fill_data),
    .in_valid  (state_q == adcsd_pkg::ST_PUSH),
    .in_ready  (fill_ready),
    .out_data  (head_data),
    .out_valid (head_valid),
    .out_ready (pop)
  );

  // flash pattern during start-up; blank flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_q <= 1'b1;
    end else if (state_q == adcsd_pkg::ST_INIT) begin
      blank_q <= flash_blank_q;
    end else if (pop) begin
      blank_q <= head_data.blank;
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_digit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        digits_q[4*g +: 4] <= 4'h0;
      end else if (state_q == adcsd_pkg::ST_INIT) begin
        digits_q[4*g +: 4] <= 4'(`ADCSD_FLASH_DIGITS >> (4*g));
      end else if (pop) begin
        digits_q[4*g +: 4] <= head_data.value[4*g +: 4];
      end
    end
  end

  // Outputs straight from flops
  assign ctrl_serial_clock_out = sclk_q;
  assign ctrl_serial_data_out  = dout_q;
  assign conv_cs_n             = cs_n_q;
  assign display_digits        = digits_q;
  assign display_blank         = blank_q;
endmodule : adcsd_ctrl

//--- adcsd_ctrl_tb_top.sv
// Self-checking bench for the channel controller
`timescale 1ns/1ns
module adcsd_ctrl_tb_top;
  logic clk = 0, rst_n = 0, dr = 1, sin, sout, sclk, cs_n, blank;
  logic [3:0] sw = 4'h0;
  logic [11:0] dig, cmd;
  logic [3:0] codes [6] = '{4'h2, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  int failures = 0, tests_run = 0, cyc = 0;
  always #4 clk = ~clk;
  adcsd_ctrl #(.SLOW_CYC(2600), .FAST_CYC(2000), .FLASH_CYC(100)) u_dut (
    .clk(clk), .rst_n(rst_n), .channel_select_switch(sw),
    .ctrl_serial_data_in(sin), .ctrl_serial_data_out(sout),
    .ctrl_serial_clock_out(sclk), .conv_cs_n(cs_n), .disp_ready(dr),
    .display_digits(dig), .display_blank(blank));
  adcsd_adc_model u_adc (.sclk(sclk), .cs_n(cs_n), .din(sout),
    .dout(sin), .last_cmd(cmd));
  // Hang guard: the whole run needs about 80k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk12(input string n, input logic [11:0] e, g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk12
  task automatic chk1(input string n, input logic e, g);
    chk12(n, {11'h000, e}, {11'h000, g});
  endtask : chk1
  function automatic logic [11:0] exp_val(input logic [3:0] c);
    case (c)
      4'hB: return 12'h800;
      4'hC: return 12'h000;
      4'hD: return 12'hFFF;
      4'hF: return 12'h444;
      default: return {3{c}};
    endcase
  endfunction : exp_val
  // One exchange, then time for conversion wait, push and display
  task automatic frame();
    int i;
    for (i = 0; i < 6000 && cs_n === 1'b1; i++) @(negedge clk);
    chk1("frame start", 1'b0, cs_n);
    while (cs_n === 1'b0) @(negedge clk);
    repeat (1300) @(negedge clk);
  endtask : frame
  task automatic do_reset(input bit mid);
    int i;
    for (i = 0; mid && i < 6000 && cs_n !== 1'b0; i++) @(negedge clk);
    if (mid) repeat (100) @(negedge clk);
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    chk1("select", 1'b1, cs_n);
    chk1("clock", 1'b0, sclk);
    chk1("blank", 1'b1, blank);
    chk12("digits", 12'h000, dig);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk12("flash", 12'h888, dig);
    repeat (148) @(negedge clk);
    chk1("flash off", 1'b1, blank);
    repeat (550) @(negedge clk);
    chk1("flash end", 1'b0, blank);
    chk12("flash hold", 12'h888, dig);
    $display("test reset %0d done", mid);
  endtask : do_reset
  task automatic test_code(input logic [3:0] c);
    logic [3:0] a;
    a = (c == 4'hF) ? 4'h4 : c;
    sw = c;
    frame();
    frame();
    chk12("command", {a, 8'h00}, cmd);
    if (c != 4'hE) chk12("digits", exp_val(c), dig);
    chk1("blank", c == 4'hE, blank);
    $display("test code %h done", c);
  endtask : test_code
  // Display stalls: fifo fills, sequencer must hold, then drain
  task automatic test_fill();
    int i;
    logic fell;
    fell = 1'b0;
    dr = 1'b0;
    repeat (17) frame();
    for (i = 0; i < 6000; i++) begin
      @(negedge clk);
      if (cs_n !== 1'b1) fell = 1'b1;
    end
    chk1("stall", 1'b0, fell);
    dr = 1'b1;
    frame();
    chk12("drain", 12'h444, dig);
    $display("test fill done");
  endtask : test_fill
  task automatic end_sim();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    do_reset(1'b0);
    foreach (codes[k]) test_code(codes[k]);
    test_fill();
    do_reset(1'b1);
    test_code(4'hF);
    end_sim();
  end
endmodule : adcsd_ctrl_tb_top

//--- adcsd_pkg.sv
// Types shared by the channel controller
package adcsd_pkg;

  // One converted reading bound for the displays
  typedef struct packed {
    logic        blank;
    logic [11:0] value;
  } adcsd_sample_type;

  typedef enum logic [2:0] {
    ST_INIT, ST_WAIT, ST_XFER, ST_CONV, ST_PUSH
  } adcsd_state_type;

endpackage : adcsd_pkg
